// *** core/vcc_pkg.sv ***
// vcc_pkg: constants shared by the virtual channel capability register bank
// assumes a 32-bit apb slave with a 12-bit configuration-space byte address
package vcc_pkg;

  // ****************************************
  // bus and register map
  // ****************************************
  localparam int              ADDR_W          = 12;
  localparam int              DATA_W          = 32;
  localparam logic [11:0]     OFS_CAP_HEADER  = 12'h140;
  localparam logic [11:0]     OFS_CAP_ONE     = 12'h144;
  localparam logic [11:0]     OFS_CAP_TWO     = 12'h148;
  localparam logic [11:0]     OFS_CTRL_STATUS = 12'h14C;

  // ****************************************
  // fixed field values
  // ****************************************
  localparam logic [15:0]     CAP_ID          = 16'h0002;
  localparam logic [3:0]      CAP_VERSION     = 4'h1;
  localparam logic [11:0]     NEXT_CAP_PTR    = 12'h20C;
  localparam logic [1:0]      REF_CLK_100NS   = 2'h0;
  localparam logic [1:0]      ENTRY_SIZE_4BIT = 2'h2;
  localparam logic [7:0]      ARB_CAP_STRAP   = 8'h03;
  localparam logic [7:0]      ARB_CAP_NONE    = 8'h00;
  localparam logic [7:0]      TBL_OFS_STRAP   = 8'h03;
  localparam logic [7:0]      TBL_OFS_NONE    = 8'h00;
  localparam logic [2:0]      COUNT_RESET     = 3'h0;
  localparam logic [2:0]      SEL_RESET       = 3'h0;
  localparam logic [2:0]      SEL_WRR         = 3'h1;
  localparam logic [31:0]     WORD_ZERO       = 32'h0000_0000;

  // ****************************************
  // field positions
  // ****************************************
  localparam int              HDR_VER_LSB     = 16;
  localparam int              HDR_PTR_LSB     = 20;
  localparam int              C1_LP_LSB       = 4;
  localparam int              C1_REF_LSB      = 8;
  localparam int              C1_SIZE_LSB     = 10;
  localparam int              C2_OFS_LSB      = 24;
  localparam int              CTL_LOAD_BIT    = 0;
  localparam int              CTL_SEL_LSB     = 1;
  localparam int              STS_TABLE_BIT   = 16;

  // ****************************************
  // timing
  // ****************************************
  localparam int              LOAD_CYCLES     = 8;

endpackage : vcc_pkg

// *** core/vcc_load_if.sv ***
// vcc_load_if: handshake between the register bank and the table loader
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface vcc_load_if;
  logic start;
  logic busy;
  logic done;

  modport ctrl   (output start, input  busy, input  done);
  modport loader (input  start, output busy, output done);
endinterface : vcc_load_if

// *** core/vcc_table_loader.sv ***
// vcc_table_loader: sequences the transfer of the stored arbitration table
// assumes start is a one-cycle pulse; starts while busy are ignored
`timescale 1ns/1ps
module vcc_table_loader #(
  parameter int LOAD_CYCLES = vcc_pkg::LOAD_CYCLES
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // handshake
  vcc_load_if.loader lif
);
  import vcc_pkg::*;

  localparam int CNT_W = $clog2(LOAD_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(LOAD_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  logic [CNT_W-1:0] cnt_q;
  logic             busy_q;
  logic             done_q;

  assign lif.busy = busy_q;
  assign lif.done = done_q;

  // ****************************************
  // load sequencer
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= CNT_ZERO;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!busy_q) begin
        if (lif.start) begin
          busy_q <= 1'b1;
          cnt_q  <= CNT_LAST;
        end
      end else if (cnt_q == CNT_ZERO) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule : vcc_table_loader

// *** core/vcc_regs.sv ***
// vcc_regs: virtual channel capability, control and status registers on apb
// assumes apb3 signalling on core_clk; strap is steady around reset release
// assumes autoload and table-write events are one-cycle pulses on core_clk
//
// Contract
// - The low 16 bits of the header always read the virtual channel extended capability code.
// - Header bits 19:16 always read structure version one.
// - Header bits 31:20 read the fixed pointer to the power budgeting capability.
// - The extended channel count resets to zero in bits 2:1 and to the strap in bit 0; autoload may override it.
// - The low-priority group count resets to zero and only autoload can change it.
// - The reference clock field reads zero, meaning a 100 ns time base.
// - The table entry size field reads binary 10, meaning four-bit entries.
// - The arbitration capability byte reads 03h with the strap set and 00h otherwise.
// - The arbitration capability is only meaningful while the low-priority group count is non-zero.
// - The arbitration table offset byte reads 03h with the strap set and 00h otherwise.
// - Writing one to the load bit applies the programmed table, and the bit always reads zero.
// - The arbitration select field resets to zero and any value but zero or one acts as the default scheme.
// - The table status bit sets when software writes any table entry and resets to zero.
// - The table status bit clears when hardware finishes loading the table after a load command.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module vcc_regs #(
  parameter int LOAD_CYCLES = vcc_pkg::LOAD_CYCLES
) (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [vcc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [vcc_pkg::DATA_W-1:0]  pwdata,
  output logic      [vcc_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  // strap and autoload
  input  wire logic                        extra_channel_strap,
  input  wire logic                        autoload_valid,
  input  wire logic [2:0]                  autoload_ext_count,
  input  wire logic [2:0]                  autoload_lp_count,
  // arbitration table side
  input  wire logic                        table_entry_write,
  output logic                             weighted_round_robin,
  output logic                             table_loading,
  output logic                             table_apply
);
  import vcc_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  localparam int LOAD_BOUND = LOAD_CYCLES + 4;

  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic              pready_q;
  logic              pslverr_q;
  logic              strap_q;
  logic              strap_seen_q;
  logic [2:0]        ext_count_q;
  logic [2:0]        low_priority_channel_group_q;
  logic [2:0]        arb_sel_q;
  logic              tbl_status_q;
  logic              wrr_q;
  logic              loading_q;
  logic              apply_q;
  logic              start_q;
  logic              access;
  logic              finish;
  logic              wr_ctrl;
  logic              load_cmd;
  logic              hit_any;
  logic [7:0]        arb_cap;
  logic [7:0]        tbl_ofs;

  vcc_load_if lif ();

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    addr_is = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction : addr_is

  assign access   = psel & penable;
  assign finish   = access & pready_q;
  assign hit_any  = addr_is(paddr, OFS_CAP_HEADER) | addr_is(paddr, OFS_CAP_ONE) |
                    addr_is(paddr, OFS_CAP_TWO) | addr_is(paddr, OFS_CTRL_STATUS);
  assign wr_ctrl  = finish & pwrite & addr_is(paddr, OFS_CTRL_STATUS);
  assign load_cmd = wr_ctrl & pwdata[CTL_LOAD_BIT];

  // ****************************************
  // apb handshake: one wait state per access
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & ~hit_any;
    end
  end

  // ****************************************
  // strap capture and autoloaded counts
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_q      <= 1'b0;
      strap_seen_q <= 1'b0;
    end else if (!strap_seen_q) begin
      strap_q      <= extra_channel_strap;
      strap_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_count_q <= COUNT_RESET;
    end else if (!strap_seen_q) begin
      ext_count_q <= {2'b00, extra_channel_strap};
    end else if (autoload_valid) begin
      ext_count_q <= autoload_ext_count;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      low_priority_channel_group_q <= COUNT_RESET;
    end else if (strap_seen_q && autoload_valid) begin
      low_priority_channel_group_q <= autoload_lp_count;
    end
  end

  // capability and table offset follow the captured strap
  assign arb_cap = strap_q ? ARB_CAP_STRAP : ARB_CAP_NONE;
  assign tbl_ofs = strap_q ? TBL_OFS_STRAP : TBL_OFS_NONE;

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      arb_sel_q <= SEL_RESET;
    end else if (wr_ctrl) begin
      arb_sel_q <= pwdata[CTL_SEL_LSB +: 3];
    end
  end

  // unsupported select codes fall back to the default scheme
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrr_q <= 1'b0;
    end else begin
      wrr_q <= (arb_sel_q == SEL_WRR);
    end
  end

  // load command is a pulse; nothing of it is stored for readback
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      start_q <= 1'b0;
    end else begin
      start_q <= load_cmd;
    end
  end

  assign lif.start = start_q;

  vcc_table_loader #(
    .LOAD_CYCLES (LOAD_CYCLES)
  ) u_loader (
    .core_clk (core_clk),
    .rst      (rst),
    .lif      (lif)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      loading_q <= 1'b0;
      apply_q   <= 1'b0;
    end else begin
      loading_q <= lif.busy;
      apply_q   <= lif.done;
    end
  end

  // ****************************************
  // table status: a new write wins over a finishing load
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tbl_status_q <= 1'b0;
    end else if (table_entry_write) begin
      tbl_status_q <= 1'b1;
    end else if (lif.done) begin
      tbl_status_q <= 1'b0;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_comb begin
    rdata_d = WORD_ZERO;
    if (addr_is(paddr, OFS_CAP_HEADER)) begin
      rdata_d[15:0]               = CAP_ID;
      rdata_d[HDR_VER_LSB +: 4]   = CAP_VERSION;
      rdata_d[HDR_PTR_LSB +: 12]  = NEXT_CAP_PTR;
    end else if (addr_is(paddr, OFS_CAP_ONE)) begin
      rdata_d[2:0]                = ext_count_q;
      rdata_d[C1_LP_LSB +: 3]     = low_priority_channel_group_q;
      rdata_d[C1_REF_LSB +: 2]    = REF_CLK_100NS;
      rdata_d[C1_SIZE_LSB +: 2]   = ENTRY_SIZE_4BIT;
    end else if (addr_is(paddr, OFS_CAP_TWO)) begin
      // presented always; software ignores it while the group count is zero
      rdata_d[7:0]                = arb_cap;
      rdata_d[C2_OFS_LSB +: 8]    = tbl_ofs;
    end else if (addr_is(paddr, OFS_CTRL_STATUS)) begin
      rdata_d[CTL_LOAD_BIT]       = 1'b0;
      rdata_d[CTL_SEL_LSB +: 3]   = arb_sel_q;
      rdata_d[STS_TABLE_BIT]      = tbl_status_q;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata_q <= WORD_ZERO;
    end else if (access && !pready_q && !pwrite) begin
      prdata_q <= rdata_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata               = prdata_q;
  assign pready               = pready_q;
  assign pslverr              = pslverr_q;
  assign weighted_round_robin = wrr_q;
  assign table_loading        = loading_q;
  assign table_apply          = apply_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence rd_done(logic [11:0] ofs);
    finish && !pwrite && addr_is(paddr, ofs);
  endsequence

  chk_header_cap_id: assert property (
    rd_done(OFS_CAP_HEADER) |-> prdata_q[15:0] == CAP_ID)
    else $error("header capability id wrong");

  chk_header_version: assert property (
    rd_done(OFS_CAP_HEADER) |-> prdata_q[HDR_VER_LSB +: 4] == CAP_VERSION)
    else $error("header version wrong");

  chk_header_next_ptr: assert property (
    rd_done(OFS_CAP_HEADER) |-> prdata_q[HDR_PTR_LSB +: 12] == NEXT_CAP_PTR)
    else $error("next capability pointer wrong");

  chk_ext_count_strap: assert property (
    !strap_seen_q ##1 strap_seen_q |-> ext_count_q == {2'b00, $past(extra_channel_strap)})
    else $error("extended count does not follow strap");

  chk_lp_count_stable: assert property (
    !autoload_valid |=> $stable(low_priority_channel_group_q))
    else $error("low priority count changed without autoload");

  chk_fixed_clk_size: assert property (
    rd_done(OFS_CAP_ONE) |-> prdata_q[C1_REF_LSB +: 2] == REF_CLK_100NS &&
                            prdata_q[C1_SIZE_LSB +: 2] == ENTRY_SIZE_4BIT)
    else $error("reference clock or entry size wrong");

  chk_cap_two_strap: assert property (
    rd_done(OFS_CAP_TWO) |-> prdata_q[7:0] == (strap_q ? ARB_CAP_STRAP : ARB_CAP_NONE) &&
                            prdata_q[C2_OFS_LSB +: 8] == (strap_q ? TBL_OFS_STRAP : TBL_OFS_NONE))
    else $error("capability two does not follow strap");

  chk_load_reads_zero: assert property (
    rd_done(OFS_CTRL_STATUS) |-> !prdata_q[CTL_LOAD_BIT])
    else $error("load bit read back as one");

  chk_load_applies: assert property (
    load_cmd && !lif.busy && !start_q |-> ##[1:LOAD_BOUND] apply_q)
    else $error("load command never applied the table");

  chk_select_default: assert property (
    ##1 $stable(arb_sel_q) |=> wrr_q == ($past(arb_sel_q) == SEL_WRR))
    else $error("arbitration select decoded wrongly");

  chk_status_set: assert property (
    table_entry_write |=> tbl_status_q ##1 (tbl_status_q || $past(lif.done)))
    else $error("table status not set by entry write");

  chk_status_clear: assert property (
    lif.done && !table_entry_write |=> !tbl_status_q)
    else $error("table status not cleared after load");

  chk_reserved_zero: assert property (
    rd_done(OFS_CAP_ONE) |-> prdata_q[31:12] == 20'h0_0000 && !prdata_q[3] && !prdata_q[7])
    else $error("reserved bits read non-zero");

  chk_ext_count_hold: assert property (
    strap_seen_q && !autoload_valid |=> $stable(ext_count_q))
    else $error("extended count changed without autoload");

  chk_lp_count_reset: assert property (
    !strap_seen_q |-> low_priority_channel_group_q == COUNT_RESET)
    else $error("low priority count not cleared by reset");

  chk_ctrl_reset: assert property (
    !strap_seen_q |-> arb_sel_q == SEL_RESET && !tbl_status_q)
    else $error("control or status not cleared by reset");

  chk_status_hold: assert property (
    !table_entry_write && !lif.done |=> $stable(tbl_status_q))
    else $error("table status changed without an event");

  chk_apply_pulse: assert property (
    apply_q |=> !apply_q)
    else $error("table apply held longer than one cycle");

  chk_unmapped_error: assert property (
    finish && !hit_any |-> pslverr_q && (pwrite || prdata_q == WORD_ZERO))
    else $error("unmapped access not refused");

  chk_ctrl_reserved: assert property (
    rd_done(OFS_CTRL_STATUS) |-> prdata_q[15:4] == 12'h000 && prdata_q[31:17] == 15'h0000)
    else $error("control or status reserved bits non-zero");

  chk_cap_two_reserved: assert property (
    rd_done(OFS_CAP_TWO) |-> prdata_q[23:8] == 16'h0000)
    else $error("capability two reserved bits non-zero");

  cov_load_done: cover property (load_cmd ##[1:LOAD_BOUND] apply_q);
  cov_select_other: cover property (wr_ctrl && pwdata[CTL_SEL_LSB +: 3] > SEL_WRR);
  cov_unmapped: cover property (finish && pslverr_q);
  cov_autoload: cover property (strap_seen_q && autoload_valid);
  cov_write_during_load: cover property (table_entry_write && lif.done);

endmodule : vcc_regs

// *** sim/vcc_regs_tb.sv ***
// vcc_regs_tb: self-checking apb bench for the virtual channel capability registers
// assumes vcc_regs answers each apb access with one wait state; load time shortened by parameter
`timescale 1ns/1ps
module vcc_regs_tb;
  import vcc_pkg::*;

  // ****************************************
  // signals
  // ****************************************
  localparam int      LOADS = 2;
  logic               core_clk;
  logic               rst;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [ADDR_W-1:0]  paddr;
  logic [DATA_W-1:0]  pwdata;
  logic [DATA_W-1:0]  prdata;
  logic               pready;
  logic               pslverr;
  logic               extra_channel_strap;
  logic               autoload_valid;
  logic [2:0]         autoload_ext_count;
  logic [2:0]         autoload_lp_count;
  logic               table_entry_write;
  logic               weighted_round_robin;
  logic               table_loading;
  logic               table_apply;
  logic [31:0]        rd;
  logic               err;
  logic               seen_load;
  logic               seen_apply;
  int                 mismatches;
  int                 tests_run;
  int                 cycles;

  vcc_regs #(.LOAD_CYCLES(LOADS)) uut (
    .core_clk             (core_clk),
    .rst                  (rst),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .extra_channel_strap  (extra_channel_strap),
    .autoload_valid       (autoload_valid),
    .autoload_ext_count   (autoload_ext_count),
    .autoload_lp_count    (autoload_lp_count),
    .table_entry_write    (table_entry_write),
    .weighted_round_robin (weighted_round_robin),
    .table_loading        (table_loading),
    .table_apply          (table_apply)
  );

  // ****************************************
  // clock and timeout
  // ****************************************
  always #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : check

  // one apb transfer: setup, access held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0000_0000);
    check(exp, rd);
    check(32'h0000_0000, {31'h0, err});
  endtask : rd_chk

  task automatic do_reset(input logic strap);
    @(posedge core_clk);
    rst                 <= 1'b1;
    extra_channel_strap <= strap;
    repeat (6) @(posedge core_clk);
    rst                 <= 1'b0;
  endtask : do_reset

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    core_clk            = 1'b0;
    rst                 = 1'b1;
    psel                = 1'b0;
    penable             = 1'b0;
    pwrite              = 1'b0;
    paddr               = 12'h000;
    pwdata              = 32'h0000_0000;
    extra_channel_strap = 1'b1;
    autoload_valid      = 1'b0;
    autoload_ext_count  = 3'h0;
    autoload_lp_count   = 3'h0;
    table_entry_write   = 1'b0;
    mismatches          = 0;
    tests_run           = 0;
    cycles              = 0;
    do_reset(1'b1);
    rd_chk(OFS_CAP_HEADER, 32'h20C1_0002);
    rd_chk(OFS_CAP_ONE, 32'h0000_0801);
    rd_chk(OFS_CAP_TWO, 32'h0300_0003);
    rd_chk(OFS_CTRL_STATUS, 32'h0000_0000);
    apb(1'b1, OFS_CAP_HEADER, 32'hFFFF_FFFF);
    rd_chk(OFS_CAP_HEADER, 32'h20C1_0002);
    apb(1'b1, OFS_CAP_ONE, 32'hFFFF_FFFF);
    rd_chk(OFS_CAP_ONE, 32'h0000_0801);
    // select one with every reserved bit set
    apb(1'b1, OFS_CTRL_STATUS, 32'hFFFF_FFF2);
    rd_chk(OFS_CTRL_STATUS, 32'h0000_0002);
    check(32'h1, {31'h0, weighted_round_robin});
    apb(1'b1, OFS_CTRL_STATUS, 32'h0000_000A);
    rd_chk(OFS_CTRL_STATUS, 32'h0000_000A);
    check(32'h0, {31'h0, weighted_round_robin});
    // table entry written, then load with select one
    @(posedge core_clk);
    table_entry_write <= 1'b1;
    @(posedge core_clk);
    table_entry_write <= 1'b0;
    rd_chk(OFS_CTRL_STATUS, 32'h0001_000A);
    apb(1'b1, OFS_CTRL_STATUS, 32'h0000_0003);
    seen_load  = 1'b0;
    seen_apply = 1'b0;
    for (int i = 0; i < 30 && seen_apply !== 1'b1; i++) begin
      @(posedge core_clk);
      if (table_loading === 1'b1) begin
        seen_load = 1'b1;
      end
      if (table_apply === 1'b1) begin
        seen_apply = 1'b1;
      end
    end
    check(32'h1, {31'h0, seen_load});
    check(32'h1, {31'h0, seen_apply});
    rd_chk(OFS_CTRL_STATUS, 32'h0000_0002);
    check(32'h1, {31'h0, weighted_round_robin});
    // autoload overrides both counts
    @(posedge core_clk);
    autoload_valid     <= 1'b1;
    autoload_ext_count <= 3'h5;
    autoload_lp_count  <= 3'h2;
    @(posedge core_clk);
    autoload_valid     <= 1'b0;
    rd_chk(OFS_CAP_ONE, 32'h0000_0825);
    rd_chk(OFS_CAP_TWO, 32'h0300_0003);
    // unmapped address
    apb(1'b0, 12'h150, 32'h0000_0000);
    check(32'h0000_0001, {31'h0, err});
    check(32'h0000_0000, rd);
    apb(1'b1, 12'h150, 32'hFFFF_FFFF);
    check(32'h0000_0001, {31'h0, err});
    // second reset with the strap low
    do_reset(1'b0);
    rd_chk(OFS_CAP_ONE, 32'h0000_0800);
    rd_chk(OFS_CAP_TWO, 32'h0000_0000);
    rd_chk(OFS_CTRL_STATUS, 32'h0000_0000);
    check(32'h0, {31'h0, weighted_round_robin});
    give_verdict();
  end

endmodule : vcc_regs_tb
